// ==== pkg/dpgpio_defs.svh ====
// Register offsets, field positions and reset values of the dual GPIO port
`ifndef DPGPIO_DEFS_SVH
`define DPGPIO_DEFS_SVH

// ============================================================
// Register byte offsets
`define DPGPIO_PORT_A_DATA_OFS       12'h000
`define DPGPIO_PORT_A_DIRECTION_OFS  12'h004
`define DPGPIO_PORT_B_DATA_OFS       12'h008
`define DPGPIO_PORT_B_DIRECTION_OFS  12'h00C
`define DPGPIO_PULLUP_OPTION_OFS     12'h010
`define DPGPIO_EXPANSION_MODE_OFS    12'h014

// ============================================================
// Field positions
`define DPGPIO_PORT_A_PULLUP_BIT     4
`define DPGPIO_PORT_B_PULLUP_BIT     5

// ============================================================
// Reset values
`define DPGPIO_DIRECTION_RST         8'hFF
`define DPGPIO_LATCH_RST             8'h00
`define DPGPIO_PULLUP_RST            8'h00
`define DPGPIO_MODE_RST              4'h0

// ============================================================
// Expansion mode codes
`define DPGPIO_MODE_PORT             4'h0
`define DPGPIO_MODE_BUS_FIRST        4'h3
`define DPGPIO_MODE_BUS_LAST         4'h9
`define DPGPIO_MODE_B_ONE_PAIR       4'h3
`define DPGPIO_MODE_B_TWO_PAIRS      4'h4
`define DPGPIO_MODE_B_THREE_PAIRS    4'h5

`endif

// ==== pkg/dpgpio_pkg.sv ====
// Types shared by the dual GPIO port design
`default_nettype none
package dpgpio_pkg;
   typedef logic [7:0] dpgpio_byte_t;
   typedef logic [3:0] dpgpio_mode_t;
   typedef logic [2:0] dpgpio_pairs_t;
endpackage
`default_nettype wire

// ==== core/dpgpio_top.sv ====
// Dual 8-bit GPIO port with external bus takeover, APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "dpgpio_defs.svh"

module dpgpio_top
   import dpgpio_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [7:0]  i_pa_in,
   output logic      [7:0]  o_pa_out,
   output logic      [7:0]  o_pa_oe,
   output logic      [7:0]  o_pa_pullup,
   input  wire logic [7:0]  i_pb_in,
   output logic      [7:0]  o_pb_out,
   output logic      [7:0]  o_pb_oe,
   output logic      [7:0]  o_pb_pullup,
   input  wire logic        i_ext_access,
   input  wire logic        i_ext_ad_oe,
   input  wire logic [7:0]  i_ext_ad_out,
   input  wire logic [7:0]  i_ext_addr_mid,
   output logic      [7:0]  o_ext_ad_in,
   output logic             o_port_a_bus,
   output logic      [7:0]  o_port_b_addr
);

   // ============================================================
   // Registers
   dpgpio_byte_t port_a_latch;
   dpgpio_byte_t port_a_direction;
   dpgpio_byte_t port_b_latch;
   dpgpio_byte_t port_b_direction;
   dpgpio_byte_t pullup_option_low;
   dpgpio_mode_t memory_expansion_mode;

   logic port_a_pullup_enable;
   logic port_b_pullup_enable;
   assign port_a_pullup_enable = pullup_option_low[`DPGPIO_PORT_A_PULLUP_BIT];
   assign port_b_pullup_enable = pullup_option_low[`DPGPIO_PORT_B_PULLUP_BIT];

   // ============================================================
   // APB decode
   logic setup_phase;
   logic wr_done;
   logic sel_a_data;
   logic sel_a_dir;
   logic sel_b_data;
   logic sel_b_dir;
   logic sel_pullup;
   logic sel_mode;
   logic addr_hit;

   assign setup_phase = i_psel & ~i_penable;
   assign wr_done     = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
   assign sel_a_data  = (i_paddr == `DPGPIO_PORT_A_DATA_OFS);
   assign sel_a_dir   = (i_paddr == `DPGPIO_PORT_A_DIRECTION_OFS);
   assign sel_b_data  = (i_paddr == `DPGPIO_PORT_B_DATA_OFS);
   assign sel_b_dir   = (i_paddr == `DPGPIO_PORT_B_DIRECTION_OFS);
   assign sel_pullup  = (i_paddr == `DPGPIO_PULLUP_OPTION_OFS);
   assign sel_mode    = (i_paddr == `DPGPIO_EXPANSION_MODE_OFS);
   assign addr_hit    = sel_a_data | sel_a_dir | sel_b_data | sel_b_dir | sel_pullup | sel_mode;

   // ============================================================
   // Expansion mode decode
   logic          port_a_bus;
   dpgpio_pairs_t port_b_pairs;
   dpgpio_byte_t  port_b_addr;

   always_comb begin
      port_a_bus = (memory_expansion_mode >= `DPGPIO_MODE_BUS_FIRST) &&
                   (memory_expansion_mode <= `DPGPIO_MODE_BUS_LAST);
   end

   always_comb begin
      case (memory_expansion_mode)
         `DPGPIO_MODE_B_ONE_PAIR:    port_b_pairs = 3'h1;
         `DPGPIO_MODE_B_TWO_PAIRS:   port_b_pairs = 3'h2;
         `DPGPIO_MODE_B_THREE_PAIRS: port_b_pairs = 3'h3;
         default:                    port_b_pairs = port_a_bus ? 3'h4 : 3'h0;
      endcase
   end

   // ============================================================
   // Per-bit pin logic
   dpgpio_byte_t next_pa_out;
   dpgpio_byte_t next_pa_oe;
   dpgpio_byte_t next_pa_pullup;
   dpgpio_byte_t next_pb_out;
   dpgpio_byte_t next_pb_oe;
   dpgpio_byte_t next_pb_pullup;
   dpgpio_byte_t port_a_view;
   dpgpio_byte_t port_b_view;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
         assign port_b_addr[gi] = ((gi / 2) < port_b_pairs);

         assign next_pa_out[gi] = port_a_bus ? i_ext_ad_out[gi] : port_a_latch[gi];
         assign next_pa_oe[gi]  = port_a_bus ? (i_ext_access & i_ext_ad_oe) : ~port_a_direction[gi];

         // Port behaviour as port A, but address pins drive i_ext_addr_mid whenever i_ext_access is high
         assign next_pb_out[gi] = port_b_addr[gi] ? i_ext_addr_mid[gi] : port_b_latch[gi];
         assign next_pb_oe[gi]  = port_b_addr[gi] ? i_ext_access : ~port_b_direction[gi];

         assign next_pa_pullup[gi] = port_a_pullup_enable & port_a_direction[gi];
         assign next_pb_pullup[gi] = port_b_pullup_enable & port_b_direction[gi];

         assign port_a_view[gi] = port_a_direction[gi] ? i_pa_in[gi] : port_a_latch[gi];
         assign port_b_view[gi] = port_b_direction[gi] ? i_pb_in[gi] : port_b_latch[gi];
      end
   endgenerate

   // ============================================================
   // Output latches
   // Hold until next write
   // Write all bits regardless of direction
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         port_a_latch <= `DPGPIO_LATCH_RST;
      end else if (wr_done && sel_a_data) begin
         port_a_latch <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         port_b_latch <= `DPGPIO_LATCH_RST;
      end else if (wr_done && sel_b_data) begin
         port_b_latch <= i_pwdata[7:0];
      end
   end

   // ============================================================
   // Direction registers
   // Reset to all inputs
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         port_a_direction <= `DPGPIO_DIRECTION_RST;
      end else if (wr_done && sel_a_dir) begin
         port_a_direction <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         port_b_direction <= `DPGPIO_DIRECTION_RST;
      end else if (wr_done && sel_b_dir) begin
         port_b_direction <= i_pwdata[7:0];
      end
   end

   // ============================================================
   // Pull-up option and expansion mode
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         pullup_option_low <= `DPGPIO_PULLUP_RST;
      end else if (wr_done && sel_pullup) begin
         pullup_option_low <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         memory_expansion_mode <= `DPGPIO_MODE_RST;
      end else if (wr_done && sel_mode) begin
         memory_expansion_mode <= i_pwdata[3:0];
      end
   end

   // ============================================================
   // APB answer
   // One wait-free access phase; read data caught at setup
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= setup_phase;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= setup_phase & ~addr_hit;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h0000_0000;
      end else if (setup_phase && !i_pwrite) begin
         case (1'b1)
            sel_a_data: o_prdata <= {24'h00_0000, port_a_view};
            sel_a_dir:  o_prdata <= {24'h00_0000, port_a_direction};
            sel_b_data: o_prdata <= {24'h00_0000, port_b_view};
            sel_b_dir:  o_prdata <= {24'h00_0000, port_b_direction};
            sel_pullup: o_prdata <= {24'h00_0000, pullup_option_low};
            sel_mode:   o_prdata <= {28'h000_0000, memory_expansion_mode};
            default:    o_prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ============================================================
   // Pin outputs, registered
   // Buffers off and pulls off in reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_pa_out    <= `DPGPIO_LATCH_RST;
         o_pa_oe     <= 8'h00;
         o_pa_pullup <= 8'h00;
      end else begin
         o_pa_out    <= next_pa_out;
         o_pa_oe     <= next_pa_oe;
         o_pa_pullup <= next_pa_pullup;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_pb_out    <= `DPGPIO_LATCH_RST;
         o_pb_oe     <= 8'h00;
         o_pb_pullup <= 8'h00;
      end else begin
         o_pb_out    <= next_pb_out;
         o_pb_oe     <= next_pb_oe;
         o_pb_pullup <= next_pb_pullup;
      end
   end

   // ============================================================
   // Status toward the external bus logic
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_ext_ad_in   <= 8'h00;
         o_port_a_bus  <= 1'b0;
         o_port_b_addr <= 8'h00;
      end else begin
         o_ext_ad_in   <= i_pa_in;
         o_port_a_bus  <= port_a_bus;
         o_port_b_addr <= port_b_addr;
      end
   end

endmodule

`default_nettype wire

// ==== dv/dpgpio_checker.sv ====
// Port assertions for the dual GPIO port
`timescale 1ns/1ps
`default_nettype none
module dpgpio_checker (
   input wire logic       i_clk,
   input wire logic       i_rst_b,
   input wire logic       i_psel,
   input wire logic       i_penable,
   input wire logic       i_pwrite,
   input wire logic       o_pready,
   input wire logic       i_ext_access,
   input wire logic       i_ext_ad_oe,
   input wire logic [7:0] i_ext_ad_out,
   input wire logic [7:0] i_ext_addr_mid,
   input wire logic [7:0] o_pa_out,
   input wire logic [7:0] o_pa_oe,
   input wire logic [7:0] o_pa_pullup,
   input wire logic [7:0] o_pb_out,
   input wire logic [7:0] o_pb_oe,
   input wire logic [7:0] o_pb_pullup,
   input wire logic       o_port_a_bus,
   input wire logic [7:0] o_port_b_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ==========
   // Assertions
   a_reset_float: assert property (disable iff (1'h0) !i_rst_b |=> o_pa_oe == 8'h00 && o_pb_oe == 8'h00)
      else $error("buffers on after reset");
   a_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
   // Mode changes also move the pins, so only steady port mode counts
   a_latch_hold: assert property ($changed(o_pa_out) && !o_port_a_bus && $stable(o_port_a_bus) |->
      $past(o_pready, 2) && $past(i_pwrite, 2))
      else $error("port A drive changed without a write");
   a_bus_drive: assert property (i_ext_access && i_ext_ad_oe |=>
      !o_port_a_bus || (o_pa_oe == 8'hFF && o_pa_out == $past(i_ext_ad_out)))
      else $error("bus byte not driven");
   a_bus_idle: assert property (!(i_ext_access && i_ext_ad_oe) |=> !o_port_a_bus || o_pa_oe == 8'h00)
      else $error("bus pins driven outside access");
   a_addr_drive: assert property (i_ext_access |=> (o_pb_oe & o_port_b_addr) == o_port_b_addr
      && ((o_pb_out ^ $past(i_ext_addr_mid)) & o_port_b_addr) == 8'h00)
      else $error("middle address not driven");
   a_addr_pairs: assert property (o_port_b_addr inside {8'h00, 8'h03, 8'h0F, 8'h3F, 8'hFF})
      else $error("address pins not in pairs");
   a_pullup_a: assert property (!o_port_a_bus |-> (o_pa_pullup & o_pa_oe) == 8'h00)
      else $error("port A pull-up on a driven pin");
   a_pullup_b: assert property ((o_pb_pullup & o_pb_oe & ~o_port_b_addr) == 8'h00)
      else $error("port B pull-up on a driven pin");
endmodule
bind dpgpio_top dpgpio_checker u_chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .o_pready, .i_ext_access,
   .i_ext_ad_oe, .i_ext_ad_out, .i_ext_addr_mid, .o_pa_out, .o_pa_oe, .o_pa_pullup, .o_pb_out, .o_pb_oe,
   .o_pb_pullup, .o_port_a_bus, .o_port_b_addr);
`default_nettype wire

// ==== dv/dpgpio_pin_model.sv ====
// External device and board wiring on one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module dpgpio_pin_model (
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_pullup,
   input  wire logic [7:0] i_drv_en,
   input  wire logic [7:0] i_drv,
   output logic      [7:0] o_pin
);
   // ==========
   // Pin level
   // Floating pins without pull-up show the inverse, so a stale drive never reads back
   assign o_pin = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv) | (~i_oe & ~i_drv_en & (i_pullup | ~i_out));
endmodule
`default_nettype wire

// ==== dv/tb_dual_port_gpio_with_bus_mux.sv ====
// Self-checking bench for the dual GPIO port
`timescale 1ns/1ps
`default_nettype none
`include "dpgpio_defs.svh"
module tb_dual_port_gpio_with_bus_mux;
   logic        i_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_ext_access, i_ext_ad_oe;
   logic        o_pready, o_pslverr, o_port_a_bus;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic [7:0]  i_pa_in, o_pa_out, o_pa_oe, o_pa_pullup, i_pb_in, o_pb_out, o_pb_oe, o_pb_pullup, drv_en, drv;
   logic [7:0]  i_ext_ad_out, i_ext_addr_mid, o_ext_ad_in, o_port_b_addr;
   int          mismatches, cmp_count;
   dpgpio_top uut (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .i_pa_in, .o_pa_out, .o_pa_oe, .o_pa_pullup, .i_pb_in, .o_pb_out, .o_pb_oe, .o_pb_pullup,
      .i_ext_access, .i_ext_ad_oe, .i_ext_ad_out, .i_ext_addr_mid, .o_ext_ad_in, .o_port_a_bus, .o_port_b_addr);
   dpgpio_pin_model u_pa (.i_oe(o_pa_oe), .i_out(o_pa_out), .i_pullup(o_pa_pullup), .i_drv_en(drv_en),
      .i_drv(drv), .o_pin(i_pa_in));
   dpgpio_pin_model u_pb (.i_oe(o_pb_oe), .i_out(o_pb_out), .i_pullup(o_pb_pullup), .i_drv_en(drv_en),
      .i_drv(drv), .o_pin(i_pb_in));
   // ==========
   // Shared tasks
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   function automatic logic [31:0] pins(input logic p);
      return {16'h0000, p ? {o_pb_oe, o_pb_out} : {o_pa_oe, o_pa_out}};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int k;
      @(posedge i_clk);
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'h1;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_pready !== 1'h1 && k < 20);
      if (o_pready !== 1'h1) begin
         mismatches++;
         test_done();
      end else begin
         r = o_prdata;
         e = o_pslverr;
         i_psel <= 1'h0;
         i_penable <= 1'h0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, {24'h000000, d}, r, e);
      chk("wr_err", {31'h0, e}, 32'h0);
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x, input logic xe = 1'h0);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      chk(n, r, x);
      chk({n, "_err"}, {31'h0, e}, {31'h0, xe});
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      rd("dir_a", `DPGPIO_PORT_A_DIRECTION_OFS, 32'hFF);
      rd("dir_b", `DPGPIO_PORT_B_DIRECTION_OFS, 32'hFF);
      rd("mode", `DPGPIO_EXPANSION_MODE_OFS, 32'h0);
      chk("oe_rst", {16'h0, o_pa_oe, o_pb_oe}, 32'h0);
      rd("unmapped", 12'h0FC, 32'h0, 1'h1);
   endtask
   task automatic t_port(input logic p);
      logic [11:0] dat;
      logic [11:0] dir;
      dat = p ? `DPGPIO_PORT_B_DATA_OFS : `DPGPIO_PORT_A_DATA_OFS;
      dir = p ? `DPGPIO_PORT_B_DIRECTION_OFS : `DPGPIO_PORT_A_DIRECTION_OFS;
      drv_en <= 8'hFF;
      drv <= 8'h3C;
      wr(dat, 8'hA5);
      tick(2);
      chk("pins_in", pins(p), 32'h00A5);
      chk("ad_in", {24'h0, o_ext_ad_in}, 32'h3C);
      rd("pin_rd", dat, 32'h3C);
      wr(dir, 8'hF0);
      tick(2);
      chk("pins_mix", pins(p), 32'h0FA5);
      rd("mix_rd", dat, 32'h35);
      wr(dat, 8'h5A);
      wr(dir, 8'h00);
      tick(2);
      chk("pins_out", pins(p), 32'hFF5A);
      rd("latch_rd", dat, 32'h5A);
      wr(dir, 8'hFF);
   endtask
   task automatic t_pullup();
      wr(`DPGPIO_PULLUP_OPTION_OFS, 8'h30);
      wr(`DPGPIO_PORT_A_DIRECTION_OFS, 8'hC3);
      tick(2);
      chk("pull", {8'h0, o_pa_oe, o_pa_pullup, o_pb_pullup}, 32'h3CC3FF);
      wr(`DPGPIO_PULLUP_OPTION_OFS, 8'h10);
      tick(2);
      chk("pull_b", {24'h0, o_pb_pullup}, 32'h0);
      wr(`DPGPIO_PULLUP_OPTION_OFS, 8'h00);
      wr(`DPGPIO_PORT_A_DIRECTION_OFS, 8'hFF);
      tick(2);
      chk("pull_off", {24'h0, o_pa_pullup}, 32'h0);
   endtask
   task automatic t_modes();
      logic [7:0] pairs;
      logic       bus;
      wr(`DPGPIO_PULLUP_OPTION_OFS, 8'h00);
      // No port A data access in bus mode
      i_ext_access <= 1'h1;
      i_ext_ad_oe <= 1'h1;
      i_ext_ad_out <= 8'hC3;
      i_ext_addr_mid <= 8'h96;
      for (int m = 0; m < 16; m++) begin
         bus = m >= 3 && m <= 9;
         pairs = m == 3 ? 8'h03 : m == 4 ? 8'h0F : m == 5 ? 8'h3F : bus ? 8'hFF : 8'h00;
         wr(`DPGPIO_EXPANSION_MODE_OFS, m[7:0]);
         tick(2);
         chk("bus", {23'h0, o_port_a_bus, o_port_b_addr}, {23'h0, bus, pairs});
         chk("pa_bus", pins(1'h0), bus ? 32'hFFC3 : 32'h005A);
         chk("pb_addr", {16'h0, o_pb_oe, o_pb_out & pairs}, {16'h0, pairs, 8'h96 & pairs});
      end
      i_ext_access <= 1'h0;
      wr(`DPGPIO_EXPANSION_MODE_OFS, 8'h09);
      tick(2);
      chk("bus_idle", {16'h0, o_pa_oe, o_pb_oe}, 32'h0);
      wr(`DPGPIO_EXPANSION_MODE_OFS, 8'h00);
   endtask
   task automatic t_midreset();
      wr(`DPGPIO_PORT_B_DIRECTION_OFS, 8'h00);
      wr(`DPGPIO_PULLUP_OPTION_OFS, 8'h10);
      tick(2);
      chk("pre_rst", {16'h0, o_pa_pullup, o_pb_oe}, 32'hFFFF);
      i_rst_b <= 1'h0;
      tick(2);
      i_rst_b <= 1'h1;
      chk("mid_rst", {16'h0, o_pa_pullup, o_pb_oe}, 32'h0);
      rd("dir_b_rst", `DPGPIO_PORT_B_DIRECTION_OFS, {24'h0, `DPGPIO_DIRECTION_RST});
      rd("pull_rst", `DPGPIO_PULLUP_OPTION_OFS, {24'h0, `DPGPIO_PULLUP_RST});
   endtask
   initial begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      mismatches = 0;
      cmp_count = 0;
      i_rst_b = 1'h0;
      i_psel = 1'h0;
      i_penable = 1'h0;
      i_pwrite = 1'h0;
      i_paddr = 12'h000;
      i_pwdata = 32'h0;
      i_ext_access = 1'h0;
      i_ext_ad_oe = 1'h0;
      i_ext_ad_out = 8'h00;
      i_ext_addr_mid = 8'h00;
      drv_en = 8'h00;
      drv = 8'h00;
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'h1;
      t_reset();
      t_port(1'h0);
      t_port(1'h1);
      t_pullup();
      t_modes();
      t_midreset();
      test_done();
   end
endmodule
`default_nettype wire
